//--- design/trip_select.sv
// trip point selection and direction compare
`timescale 1ns/100ps

module trip_select (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] limit,
    input  wire logic       dir_up,
    input  wire logic [14:0] above_int,
    input  wire logic       above_ext,
    input  wire logic       at_level,
    output logic            hit_q
);

    logic sel_above;
    logic hit_d;

    // ------------------------------------------------------------
    // source mux
    // ------------------------------------------------------------
    always_comb begin
        if (limit == vdet_pkg::limit_external) begin
            sel_above = above_ext;
        end else begin
            // code 14 is point 1 ... code 0 is point 15, index = point-1
            sel_above = above_int[4'(4'd14 - limit)];
        end
        // equal counts for both directions
        hit_d = dir_up ? (sel_above | at_level) : (~sel_above | at_level);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= hit_d;
        end
    end

endmodule : trip_select

//--- design/vdet_pkg.sv
// constants shared by the voltage detect control block
package vdet_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ctrl_off      = 12'h000;
    localparam logic [11:0] irq_stat_off  = 12'h004;
    localparam logic [11:0] irq_mask_off  = 12'h008;
    localparam logic [11:0] analog_in_off = 12'h00c;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          enable_bit    = 15;
    localparam int          idle_stop_bit = 13;
    localparam int          dir_bit       = 7;
    localparam int          bg_stable_bit = 6;
    localparam int          ref_stable_bit = 5;
    localparam int          limit_lsb     = 0;
    localparam int          limit_w       = 4;
    localparam logic [15:0] ctrl_wr_mask  = 16'ha08f;
    localparam logic [15:0] ctrl_reset    = 16'h0000;
    localparam logic [3:0]  limit_external = 4'hf;
    localparam logic [3:0]  limit_reset   = 4'h0;

    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int          evt_trip_bit  = 0;
    localparam int          evt_ref_bit   = 1;
    localparam int          evt_w         = 2;
    localparam logic [1:0]  evt_reset     = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          clk_period_ns = 10;
    localparam int          settle_ns     = 50;
    localparam int          settle_cycles = (settle_ns + clk_period_ns - 1) / clk_period_ns;

    typedef enum logic [1:0] {
        st_off,
        st_settle,
        st_watch,
        st_halted
    } det_state_t;

endpackage : vdet_pkg

//--- design/voltage_detect_control.sv
// register file, enable sequencing and flag logic of the voltage detector
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps

// How it works
// - detector runs only while control bit 15 is one; otherwise no events
// - idle-stop bit one halts the detector while the chip is idle
// - direction one trips at or above the point, zero at or below
// - crossing sets the sticky flag; interrupt output only when unmasked
// - bit 6 reads the band gap stable status
// - bit 5 reads reference stable; no flag is raised while it is zero
// - limit code 1111 compares against the external analog input pin
// - codes 1110 down to 0000 select trip points 1 to 15
// - bits 14, 12 to 8 and 4 ignore writes and read zero
module voltage_detect_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        idle_mode,
    input  wire logic        bandgap_stable,
    input  wire logic        reference_stable,
    input  wire logic [14:0] above_trip,
    input  wire logic        external_trip_input_pin,
    input  wire logic        at_trip,
    output logic             detector_power_q,
    output logic             irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]             ctrl_q;
    logic [1:0]              stat_q;
    logic [1:0]              mask_q;
    logic                    ref_seen_q;
    logic                    hit_prev_q;
    logic [7:0]              settle_q;
    vdet_pkg::det_state_t    state_q;
    logic                    hit;
    logic                    wr_acc;
    logic                    rd_acc;
    logic                    addr_ok;
    logic                    running;
    logic                    trip_evt;
    logic                    ref_evt;
    logic [1:0]              evt;
    logic [31:0]             rd_d;
    logic                    bg_now;
    logic                    ref_now;

    assign wr_acc  = psel & penable & pwrite & pready;
    assign rd_acc  = psel & penable & ~pwrite & ~pready;
    assign addr_ok = (paddr == vdet_pkg::ctrl_off) || (paddr == vdet_pkg::irq_stat_off)
                   || (paddr == vdet_pkg::irq_mask_off) || (paddr == vdet_pkg::analog_in_off);
    assign bg_now  = bandgap_stable & ctrl_q[vdet_pkg::enable_bit];
    assign ref_now = reference_stable & ctrl_q[vdet_pkg::enable_bit];

    // ------------------------------------------------------------
    // compare path
    // ------------------------------------------------------------
    trip_select u_trip (
        .pclk      (pclk),
        .presetn   (presetn),
        .limit     (ctrl_q[vdet_pkg::limit_lsb +: vdet_pkg::limit_w]),
        .dir_up    (ctrl_q[vdet_pkg::dir_bit]),
        .above_int (above_trip),
        .above_ext (external_trip_input_pin),
        .at_level  (at_trip),
        .hit_q     (hit)
    );

    // ------------------------------------------------------------
    // apb slave: one wait state; writes land on the completing edge
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            if (rd_acc) begin
                prdata <= rd_d;
            end
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            vdet_pkg::ctrl_off: begin
                rd_d[15:0] = ctrl_q & vdet_pkg::ctrl_wr_mask;
                rd_d[vdet_pkg::bg_stable_bit]  = bg_now;
                rd_d[vdet_pkg::ref_stable_bit] = ref_now;
            end
            vdet_pkg::irq_stat_off:  rd_d[1:0] = stat_q;
            vdet_pkg::irq_mask_off:  rd_d[1:0] = mask_q;
            vdet_pkg::analog_in_off: rd_d[0]   = hit;
            default:                 rd_d      = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= vdet_pkg::ctrl_reset;
        end else if (wr_acc && paddr == vdet_pkg::ctrl_off) begin
            if (pstrb[0]) begin
                ctrl_q[7:0] <= pwdata[7:0] & vdet_pkg::ctrl_wr_mask[7:0];
            end
            if (pstrb[1]) begin
                ctrl_q[15:8] <= pwdata[15:8] & vdet_pkg::ctrl_wr_mask[15:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= vdet_pkg::evt_reset;
        end else if (wr_acc && paddr == vdet_pkg::irq_mask_off && pstrb[0]) begin
            mask_q <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // detector sequencing
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= vdet_pkg::st_off;
            settle_q <= 8'h00;
        end else begin
            unique case (state_q)
                vdet_pkg::st_off: begin
                    if (ctrl_q[vdet_pkg::enable_bit]) begin
                        state_q  <= vdet_pkg::st_settle;
                        settle_q <= 8'(vdet_pkg::settle_cycles);
                    end
                end
                vdet_pkg::st_settle: begin
                    if (!ctrl_q[vdet_pkg::enable_bit]) begin
                        state_q <= vdet_pkg::st_off;
                    end else if (settle_q <= 8'h01) begin
                        state_q <= vdet_pkg::st_watch;
                    end else begin
                        settle_q <= settle_q - 8'h01;
                    end
                end
                vdet_pkg::st_watch: begin
                    if (!ctrl_q[vdet_pkg::enable_bit]) begin
                        state_q <= vdet_pkg::st_off;
                    end else if (idle_mode && ctrl_q[vdet_pkg::idle_stop_bit]) begin
                        state_q <= vdet_pkg::st_halted;
                    end
                end
                vdet_pkg::st_halted: begin
                    if (!ctrl_q[vdet_pkg::enable_bit]) begin
                        state_q <= vdet_pkg::st_off;
                    end else if (!(idle_mode && ctrl_q[vdet_pkg::idle_stop_bit])) begin
                        state_q  <= vdet_pkg::st_settle;
                        settle_q <= 8'(vdet_pkg::settle_cycles);
                    end
                end
            endcase
        end
    end

    assign running = (state_q == vdet_pkg::st_watch)
                   && ctrl_q[vdet_pkg::enable_bit]
                   && !(idle_mode && ctrl_q[vdet_pkg::idle_stop_bit]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            detector_power_q <= 1'b0;
        end else begin
            detector_power_q <= ctrl_q[vdet_pkg::enable_bit]
                              && !(idle_mode && ctrl_q[vdet_pkg::idle_stop_bit]);
        end
    end

    // ------------------------------------------------------------
    // events and sticky status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_prev_q <= 1'b0;
            ref_seen_q <= 1'b0;
        end else begin
            hit_prev_q <= hit & running;
            ref_seen_q <= ref_now;
        end
    end

    // crossing is the rising edge of the condition while armed
    assign trip_evt = running & ref_now & hit & ~hit_prev_q;
    assign ref_evt  = ref_now & ~ref_seen_q;
    always_comb begin
        evt = 2'b00;
        evt[vdet_pkg::evt_trip_bit] = trip_evt;
        evt[vdet_pkg::evt_ref_bit]  = ref_evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= vdet_pkg::evt_reset;
        end else if (wr_acc && paddr == vdet_pkg::irq_stat_off && pstrb[0]) begin
            stat_q <= (stat_q & ~pwdata[1:0]) | evt;
        end else begin
            stat_q <= stat_q | evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & mask_q);
        end
    end

endmodule : voltage_detect_control

//--- dv/voltage_detect_control_assertions.sv
// port checker for the voltage detect control block
`timescale 1ns/100ps

module vdet_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        idle_mode,
    input wire logic        detector_power_q,
    input wire logic        irq
);
    logic mapped;
    assign mapped = paddr inside {vdet_pkg::ctrl_off, vdet_pkg::irq_stat_off,
                                  vdet_pkg::irq_mask_off, vdet_pkg::analog_in_off};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_ctrl_read;
        pready && !pwrite && paddr == vdet_pkg::ctrl_off;
    endsequence

    a_ready_wait: assert property (s_access |=> pready) else $error("ready missing");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_err_unmapped: assert property (s_access ##0 !mapped |=> pslverr)
        else $error("unmapped not refused");
    a_err_mapped: assert property (s_access ##0 mapped |=> !pslverr)
        else $error("mapped refused");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_rsvd_zero: assert property (s_ctrl_read |-> (prdata & 32'h00005f10) == 32'h0)
        else $error("unimplemented bits set");
    a_flags_off: assert property (s_ctrl_read ##0 !prdata[15] |-> prdata[6:5] == 2'h0)
        else $error("stable flags while off");
    a_irq_sticky: assert property ($fell(irq) |-> $past(psel && pwrite && pready, 2))
        else $error("irq fell without a write");
    a_power_rise: assert property ($rose(detector_power_q) |->
        $past(pready && pwrite, 2) || $past(!idle_mode))
        else $error("power rose without cause");
    a_power_fall: assert property ($fell(detector_power_q) |->
        $past(pready && pwrite, 2) || $past(idle_mode))
        else $error("power fell without cause");
endmodule : vdet_checker

bind voltage_detect_control vdet_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .detector_power_q(detector_power_q), .irq(irq));

//--- dv/voltage_detect_control_test.sv
// self-checking bench for the voltage detect control block
`timescale 1ns/100ps

module voltage_detect_control_test;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, detector_power_q, irq;
    logic        idle_mode = 1'h0;
    logic        bandgap_stable = 1'h0;
    logic        reference_stable = 1'h0;
    logic [14:0] above_trip = 15'h0;
    logic        ext_pin = 1'h0;
    logic        at_lvl = 1'h0;
    logic [31:0] rd;
    logic        er;
    logic [3:0]  codes [4] = '{4'he, 4'h0, 4'hf, 4'h7};
    int          err_count = 0;
    int          checked = 0;

    always #5 pclk = ~pclk;

    voltage_detect_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .bandgap_stable(bandgap_stable),
        .reference_stable(reference_stable), .above_trip(above_trip),
        .external_trip_input_pin(ext_pin), .at_trip(at_lvl), .detector_power_q(detector_power_q),
        .irq(irq));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 20) err_count++;
    endtask : apb

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    // arm with condition false, move other inputs, then cross and fall back
    task automatic run_trip(input logic [15:0] c, input logic rf, idl, ex, ie);
        logic [15:0] v;
        int          s;
        s = (c[3:0] == 4'hf) ? 15 : 14 - int'(c[3:0]);
        v = c[7] ? 16'h0000 : 16'hffff;
        reference_stable <= rf;
        idle_mode <= idl;
        {ext_pin, above_trip} <= v;
        apb(1'h1, vdet_pkg::ctrl_off, {16'h0, c});
        repeat (10) @(posedge pclk);
        chk("detector power", detector_power_q, c[15] & ~(idl & c[13]));
        apb(1'h1, vdet_pkg::irq_stat_off, 32'h3);
        v = ~v;
        {ext_pin, above_trip} <= v ^ (16'h1 << s);
        repeat (6) @(posedge pclk);
        apb(1'h0, vdet_pkg::irq_stat_off, 32'h0);
        chk("stray trip", rd[0], 1'h0);
        {ext_pin, above_trip} <= v;
        repeat (6) @(posedge pclk);
        apb(1'h0, vdet_pkg::analog_in_off, 32'h0);
        chk("compare now", rd[0], 1'h1);
        {ext_pin, above_trip} <= v ^ (16'h1 << s);
        repeat (6) @(posedge pclk);
        apb(1'h0, vdet_pkg::irq_stat_off, 32'h0);
        chk("trip flag", rd[0], ex);
        chk("irq", irq, ex & ie);
        apb(1'h1, vdet_pkg::irq_stat_off, 32'h3);
        repeat (2) @(posedge pclk);
        chk("irq cleared", irq, 1'h0);
        apb(1'h1, vdet_pkg::ctrl_off, 32'h0);
        idle_mode <= 1'h0;
    endtask : run_trip

    // voltage sits exactly on the point: trips in either direction
    task automatic run_equal(input logic [15:0] c);
        {ext_pin, above_trip} <= c[7] ? 16'h0000 : 16'hffff;
        apb(1'h1, vdet_pkg::ctrl_off, {16'h0, c});
        repeat (10) @(posedge pclk);
        apb(1'h1, vdet_pkg::irq_stat_off, 32'h3);
        repeat (6) @(posedge pclk);
        apb(1'h0, vdet_pkg::irq_stat_off, 32'h0);
        chk("equal idle", rd[0], 1'h0);
        at_lvl <= 1'h1;
        repeat (6) @(posedge pclk);
        apb(1'h0, vdet_pkg::irq_stat_off, 32'h0);
        chk("equal trip", rd[0], 1'h1);
        at_lvl <= 1'h0;
        apb(1'h1, vdet_pkg::ctrl_off, 32'h0);
    endtask : run_equal

    // register access, read-only flags and refused addresses
    task automatic run_regs();
        apb(1'h0, vdet_pkg::ctrl_off, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        chk("mapped error", er, 1'h0);
        apb(1'h1, vdet_pkg::ctrl_off, 32'hffffffff);
        apb(1'h0, vdet_pkg::ctrl_off, 32'h0);
        chk("ctrl bits", rd, 32'h0000a08f);
        bandgap_stable <= 1'h1;
        repeat (4) @(posedge pclk);
        apb(1'h0, vdet_pkg::ctrl_off, 32'h0);
        chk("band gap flag", rd, 32'h0000a0cf);
        bandgap_stable <= 1'h0;
        reference_stable <= 1'h1;
        repeat (4) @(posedge pclk);
        apb(1'h0, vdet_pkg::ctrl_off, 32'h0);
        chk("reference flag", rd, 32'h0000a0af);
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped error", er, 1'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'h1, vdet_pkg::ctrl_off, 32'h0);
        bandgap_stable <= 1'h1;
        repeat (2) @(posedge pclk);
        apb(1'h0, vdet_pkg::ctrl_off, 32'h0);
        chk("flags while off", rd, 32'h0);
    endtask : run_regs

    // reset in mid-run clears the fields and the sticky flags
    task automatic run_reset();
        apb(1'h1, vdet_pkg::ctrl_off, 32'h0000a08f);
        repeat (10) @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        chk("power in reset", detector_power_q, 1'h0);
        apb(1'h0, vdet_pkg::ctrl_off, 32'h0);
        chk("ctrl after reset", rd, 32'h0);
        apb(1'h0, vdet_pkg::irq_stat_off, 32'h0);
        chk("status after reset", rd, 32'h0);
    endtask : run_reset

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        run_regs();
        // unmask only the trip flag; the reference flag stays masked
        apb(1'h1, vdet_pkg::irq_mask_off, 32'h1);
        for (int i = 0; i < 8; i++) begin
            run_trip({8'h80, i[0], 3'h0, codes[i / 2]}, 1'h1, 1'h0, 1'h1, 1'h1);
        end
        run_trip(16'h0085, 1'h1, 1'h0, 1'h0, 1'h1);
        run_trip(16'h8085, 1'h0, 1'h0, 1'h0, 1'h1);
        run_trip(16'ha085, 1'h1, 1'h1, 1'h0, 1'h1);
        run_trip(16'h8005, 1'h1, 1'h1, 1'h1, 1'h1);
        apb(1'h1, vdet_pkg::irq_mask_off, 32'h0);
        run_trip(16'h8005, 1'h1, 1'h0, 1'h1, 1'h0);
        run_equal(16'h8085);
        run_equal(16'h8005);
        run_reset();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        summarize();
    end
endmodule : voltage_detect_control_test
